// [dv/adc_calibration_coeff_regs_tb_top.sv]
`default_nettype none
module adc_calibration_coeff_regs_tb_top
    import cal_coeff_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    localparam int DW = 24;
    logic ref_clk, rst, wr_stb, rd_stb, prim_cal_done, aux_cal_done, prim_raw_valid;
    logic [31:0] addr, wdata, rdata, rd_val;
    logic [15:0] factory_prim_offset, factory_aux_offset, factory_prim_gain;
    logic [15:0] prim_cal_value, aux_cal_value, prim_offset_coef, aux_offset_coef, prim_gain_coef;
    logic prim_enable, aux_enable, prim_cal_start, aux_cal_start, prim_result_valid;
    logic [1:0] prim_mode, aux_mode;
    logic [DW-1:0] prim_raw, prim_result;
    int compares = 0;
    int miscompares = 0;

    adc_calibration_coeff_regs #(.DATA_W(DW)) u_adc_calibration_coeff_regs (
        .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .factory_prim_offset(factory_prim_offset),
        .factory_aux_offset(factory_aux_offset), .factory_prim_gain(factory_prim_gain),
        .prim_enable(prim_enable), .aux_enable(aux_enable), .prim_mode(prim_mode),
        .aux_mode(aux_mode), .prim_cal_start(prim_cal_start), .aux_cal_start(aux_cal_start),
        .prim_cal_done(prim_cal_done), .aux_cal_done(aux_cal_done),
        .prim_cal_value(prim_cal_value), .aux_cal_value(aux_cal_value),
        .prim_offset_coef(prim_offset_coef), .aux_offset_coef(aux_offset_coef),
        .prim_gain_coef(prim_gain_coef), .prim_raw(prim_raw), .prim_raw_valid(prim_raw_valid),
        .prim_result(prim_result), .prim_result_valid(prim_result_valid)
    );

    // ----------------------------------------------------------------
    // clock, watchdog, shared tasks
    // ----------------------------------------------------------------
    // 25 MHz system clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // whole run is about 650 cycles, so 5000 leaves ample slack
    initial begin
        #(5000 * 40);
        miscompares++;
        test_done();
    end

    task automatic test_done();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe; the slave never stalls
    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe, then fall back to zero
    task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
        @(negedge ref_clk);
        chk(rdata, 32'h00000000);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_factory();
        chk({16'h0000, prim_offset_coef}, 32'h00000010);
        chk({16'h0000, aux_offset_coef}, 32'h0000FFE0);
        chk({16'h0000, prim_gain_coef}, 32'h00008000);
        bus_rd(ADDR_AUX_OFFSET, rd_val);
        chk(rd_val, 32'h0000FFE0);
        bus_rd(ADDR_PRIM_GAIN, rd_val);
        chk(rd_val, 32'h00008000);
        $display("test factory done");
    endtask

    // writes while disabled, then while idle too briefly, must both be dropped
    task automatic t_refused();
        bus_wr(ADDR_PRIM_GAIN, 32'h00001111);
        bus_wr(ADDR_AUX_OFFSET, 32'h00001111);
        @(negedge ref_clk);
        chk({16'h0000, prim_gain_coef}, 32'h00008000);
        chk({16'h0000, aux_offset_coef}, 32'h0000FFE0);
        bus_wr(ADDR_MODE, 32'h00000300);
        bus_wr(ADDR_PRIM_OFFSET, 32'h00002222);
        @(negedge ref_clk);
        chk({30'h0, aux_enable, prim_enable}, 32'h00000003);
        chk({16'h0000, prim_offset_coef}, 32'h00000010);
        $display("test refused done");
    endtask

    // after the idle time, writes land; upper bits are dropped and read as zero
    task automatic t_idle_write();
        repeat (IDLE_MIN_CYC + 5) @(posedge ref_clk);
        bus_rd(ADDR_STATUS, rd_val);
        chk(rd_val, 32'h00000003);
        bus_wr(ADDR_PRIM_OFFSET, 32'hABCD0123);
        bus_wr(ADDR_AUX_OFFSET, 32'h5A5AC3C3);
        bus_wr(ADDR_PRIM_GAIN, 32'hFFFF4000);
        bus_rd(ADDR_PRIM_OFFSET, rd_val);
        chk(rd_val, 32'h00000123);
        bus_rd(ADDR_AUX_OFFSET, rd_val);
        chk(rd_val, 32'h0000C3C3);
        bus_rd(ADDR_PRIM_GAIN, rd_val);
        chk(rd_val, 32'h00004000);
        bus_rd(32'hFFFF0530, rd_val);
        chk(rd_val, 32'h00000000);
        $display("test idle write done");
    endtask

    // offset and gain are written first; gain 0x8000 is unity, 0x4000 one half
    task automatic t_result(input logic [DW-1:0] raw, input logic [15:0] off,
        input logic [15:0] gain);
        longint v;
        v = (longint'($signed(raw)) - longint'($signed(off))) * longint'(gain);
        v = v >>> GAIN_FRAC;
        bus_wr(ADDR_PRIM_OFFSET, {16'h0000, off});
        bus_wr(ADDR_PRIM_GAIN, {16'h0000, gain});
        @(posedge ref_clk);
        prim_raw <= raw;
        prim_raw_valid <= 1'b1;
        @(posedge ref_clk);
        prim_raw_valid <= 1'b0;
        @(negedge ref_clk);
        chk({31'h0, prim_result_valid}, 32'h00000001);
        chk({8'h00, prim_result}, {8'h00, v[DW-1:0]});
        $display("test result done");
    endtask

    // calibration start, completion, and a stray completion while idle
    task automatic t_cal(input logic [31:0] mode, input logic aux, input logic [15:0] val);
        bus_wr(ADDR_MODE, mode);
        @(negedge ref_clk);
        chk({30'h0, aux_cal_start, prim_cal_start}, aux ? 32'h2 : 32'h1);
        @(posedge ref_clk);
        aux_cal_done <= aux;
        prim_cal_done <= ~aux;
        aux_cal_value <= val;
        prim_cal_value <= val;
        @(posedge ref_clk);
        aux_cal_done <= 1'b0;
        prim_cal_done <= 1'b0;
        @(negedge ref_clk);
        chk({16'h0000, aux ? aux_offset_coef : prim_gain_coef}, {16'h0000, val});
        chk({28'h0, aux_mode, prim_mode}, 32'h00000000);
        @(posedge ref_clk);
        aux_cal_done <= aux;
        prim_cal_done <= ~aux;
        aux_cal_value <= 16'h0BAD;
        prim_cal_value <= 16'h0BAD;
        @(posedge ref_clk);
        aux_cal_done <= 1'b0;
        prim_cal_done <= 1'b0;
        @(negedge ref_clk);
        chk({16'h0000, aux ? aux_offset_coef : prim_gain_coef}, {16'h0000, val});
        $display("test calibration done");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {wr_stb, rd_stb, prim_cal_done, aux_cal_done, prim_raw_valid} = 5'h00;
        addr = 32'h00000000;
        wdata = 32'h00000000;
        prim_raw = 24'h000000;
        prim_cal_value = 16'h0000;
        aux_cal_value = 16'h0000;
        factory_prim_offset = 16'h0010;
        factory_aux_offset = 16'hFFE0;
        factory_prim_gain = 16'h8000;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        t_factory();
        t_refused();
        t_idle_write();
        t_result(24'h000110, 16'h0010, 16'h4000);
        t_result(24'hFFFF00, 16'h0010, 16'h4000);
        t_result(24'h800123, 16'h0000, 16'h8000);
        t_cal(32'h00000320, 1'b1, 16'h1357);
        t_cal(32'h00000303, 1'b0, 16'h7531);
        test_done();
    end
endmodule
`default_nettype wire

// [rtl/adc_calibration_coeff_regs.sv]
// Notes on behaviour
// - aux offset holds 16 bits at 15:0
// - primary offset holds 16 bits at 15:0
// - aux offset loads factory value at power-on
// - aux offset calibration overwrites aux offset
// - primary gain scales every primary result
// - primary gain: factory load, calibration overwrite
// - software coefficient writes accepted only in idle; mode writes always accepted
//
// Chosen here: the address-and-strobe port.
`default_nettype none
module adc_calibration_coeff_regs
    import cal_coeff_pkg::*;
#(
    parameter int DATA_W = 24
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    // factory trim values
    input wire logic [15:0] factory_prim_offset,
    input wire logic [15:0] factory_aux_offset,
    input wire logic [15:0] factory_prim_gain,
    // converter core control
    output logic prim_enable,
    output logic aux_enable,
    output logic [1:0] prim_mode,
    output logic [1:0] aux_mode,
    output logic prim_cal_start,
    output logic aux_cal_start,
    input wire logic prim_cal_done,
    input wire logic aux_cal_done,
    input wire logic [15:0] prim_cal_value,
    input wire logic [15:0] aux_cal_value,
    // coefficients to the converter path
    output logic [15:0] prim_offset_coef,
    output logic [15:0] aux_offset_coef,
    output logic [15:0] prim_gain_coef,
    // primary conversion path
    input wire logic [DATA_W-1:0] prim_raw,
    input wire logic prim_raw_valid,
    output logic [DATA_W-1:0] prim_result,
    output logic prim_result_valid
);

    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (DATA_W < 17 || DATA_W > 32) begin : g_bad_width
        $error("DATA_W must lie between 17 and 32");
    end

    // ----------------------------------------------------------------
    // state and decode
    // ----------------------------------------------------------------
    logic load_factory;
    logic [1:0] conv_en;
    logic [1:0] conv_mode [2];
    logic [1:0] wr_ok;
    logic [1:0] cal_busy;
    logic [IDLE_CNT_W-1:0] idle_cnt [2];
    logic [1:0] cal_start;
    logic [1:0] cal_done;
    logic [31:0] rd_mux;

    wire sel_prim_off = addr == ADDR_PRIM_OFFSET;
    wire sel_aux_off = addr == ADDR_AUX_OFFSET;
    wire sel_gain = addr == ADDR_PRIM_GAIN;
    wire sel_mode = addr == ADDR_MODE;
    wire sel_status = addr == ADDR_STATUS;
    wire wr_mode = wr_stb && sel_mode;

    // hardware calibration results, by kind
    wire prim_offs_load = cal_done[0] && conv_mode[0] == MODE_OFFS_CAL;
    wire prim_gain_load = cal_done[0] && conv_mode[0] == MODE_GAIN_CAL;
    wire aux_offs_load = cal_done[1] && conv_mode[1] == MODE_OFFS_CAL;

    // software writes, gated by the per-converter idle qualifier
    wire sw_prim_off = wr_stb && sel_prim_off && wr_ok[0];
    wire sw_gain = wr_stb && sel_gain && wr_ok[0];
    wire sw_aux_off = wr_stb && sel_aux_off && wr_ok[1];

    // incoming mode fields as written by software
    wire [1:0][1:0] wr_mode_fld = {wdata[MODE_AUX_LSB +: 2], wdata[MODE_PRIM_LSB +: 2]};
    wire [1:0] wr_en_fld = {wdata[MODE_EN_AUX_BIT], wdata[MODE_EN_PRIM_BIT]};

    assign cal_done = {aux_cal_done, prim_cal_done};

    // ----------------------------------------------------------------
    // factory load one edge after reset release
    // ----------------------------------------------------------------
    // the trim inputs are caught by a clock edge, never by the reset itself
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            load_factory <= 1'b1;
        end else begin
            load_factory <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // per-converter mode, idle timer and calibration start
    // ----------------------------------------------------------------
    for (genvar ch = 0; ch < 2; ch++) begin : g_conv
        wire in_idle = conv_en[ch] && conv_mode[ch] == MODE_IDLE;
        wire is_cal = conv_mode[ch] == MODE_OFFS_CAL || conv_mode[ch] == MODE_GAIN_CAL;
        wire wr_cal = wr_mode && wr_en_fld[ch] && wr_mode_fld[ch][1];

        // software wins over the hardware return to idle in the same edge
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                conv_en[ch] <= 1'b0;
                conv_mode[ch] <= MODE_RESET;
            end else if (wr_mode) begin
                conv_en[ch] <= wr_en_fld[ch];
                conv_mode[ch] <= wr_mode_fld[ch];
            end else if (cal_done[ch] && is_cal) begin
                conv_mode[ch] <= MODE_IDLE;
            end
        end

        // saturating count of edges spent enabled and idle
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                idle_cnt[ch] <= '0;
            end else if (!in_idle) begin
                idle_cnt[ch] <= '0;
            end else if (idle_cnt[ch] != IDLE_MIN) begin
                idle_cnt[ch] <= idle_cnt[ch] + 1'b1;
            end
        end

        // one-cycle start request to the converter core
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                cal_start[ch] <= 1'b0;
            end else begin
                cal_start[ch] <= wr_cal;
            end
        end

        assign wr_ok[ch] = in_idle && idle_cnt[ch] == IDLE_MIN;
        assign cal_busy[ch] = is_cal;
    end

    assign prim_enable = conv_en[0];
    assign aux_enable = conv_en[1];
    assign prim_mode = conv_mode[0];
    assign aux_mode = conv_mode[1];
    assign prim_cal_start = cal_start[0];
    assign aux_cal_start = cal_start[1];

    // ----------------------------------------------------------------
    // coefficient registers
    // ----------------------------------------------------------------
    // primary offset: factory, calibration result, or accepted write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prim_offset_coef <= COEF_RESET;
        end else if (load_factory) begin
            prim_offset_coef <= factory_prim_offset;
        end else if (prim_offs_load) begin
            prim_offset_coef <= prim_cal_value;
        end else if (sw_prim_off) begin
            prim_offset_coef <= wdata[COEF_W-1:0];
        end
    end

    // auxiliary offset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aux_offset_coef <= COEF_RESET;
        end else if (load_factory) begin
            aux_offset_coef <= factory_aux_offset;
        end else if (aux_offs_load) begin
            aux_offset_coef <= aux_cal_value;
        end else if (sw_aux_off) begin
            aux_offset_coef <= wdata[COEF_W-1:0];
        end
    end

    // primary gain
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prim_gain_coef <= COEF_RESET;
        end else if (load_factory) begin
            prim_gain_coef <= factory_prim_gain;
        end else if (prim_gain_load) begin
            prim_gain_coef <= prim_cal_value;
        end else if (sw_gain) begin
            prim_gain_coef <= wdata[COEF_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // primary result correction
    // ----------------------------------------------------------------
    // gain 0x8000 is unity; the product is truncated, not saturated
    logic signed [DATA_W:0] corr_diff;
    logic signed [DATA_W+COEF_W+1:0] corr_prod;

    assign corr_diff = $signed({prim_raw[DATA_W-1], prim_raw})
        - $signed({{(DATA_W+1-COEF_W){prim_offset_coef[COEF_W-1]}}, prim_offset_coef});
    assign corr_prod = corr_diff * $signed({1'b0, prim_gain_coef});

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prim_result <= '0;
            prim_result_valid <= 1'b0;
        end else begin
            prim_result_valid <= prim_raw_valid;
            if (prim_raw_valid) begin
                prim_result <= corr_prod[DATA_W-1+GAIN_FRAC:GAIN_FRAC];
            end
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // unmapped addresses read as zero; upper bits of coefficients read zero
    assign rd_mux = sel_prim_off ? {16'h0000, prim_offset_coef}
        : sel_aux_off ? {16'h0000, aux_offset_coef}
        : sel_gain ? {16'h0000, prim_gain_coef}
        : sel_mode ? {22'h0, conv_en, 2'h0, conv_mode[1], 2'h0, conv_mode[0]}
        : sel_status ? {28'h0000000, cal_busy, wr_ok}
        : 32'h00000000;

    // data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= rd_stb ? rd_mux : 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    aux_write_store_a: assert property (
        wr_stb && sel_aux_off && wr_ok[1] && !aux_offs_load && !load_factory
        |=> aux_offset_coef == $past(wdata[15:0]))
        else $error("accepted aux offset write not stored");

    prim_write_store_a: assert property (
        wr_stb && sel_prim_off && wr_ok[0] && !prim_offs_load && !load_factory
        |=> prim_offset_coef == $past(wdata[15:0]))
        else $error("accepted primary offset write not stored");

    factory_load_a: assert property (
        load_factory && !rst |=> aux_offset_coef == $past(factory_aux_offset)
        && prim_gain_coef == $past(factory_prim_gain)
        && prim_offset_coef == $past(factory_prim_offset) && !load_factory)
        else $error("factory values not loaded after reset");

    aux_cal_load_a: assert property (
        aux_cal_done && aux_mode == MODE_OFFS_CAL && !wr_mode
        |=> aux_offset_coef == $past(aux_cal_value) && aux_mode == MODE_IDLE)
        else $error("aux offset calibration result not taken");

    unity_scale_a: assert property (
        prim_raw_valid && prim_gain_coef == 16'h8000 && prim_offset_coef == 16'h0000
        |=> prim_result_valid && prim_result == $past(prim_raw))
        else $error("unity gain does not pass result through");

    result_valid_a: assert property (
        !prim_raw_valid |=> !prim_result_valid)
        else $error("result valid without a conversion");

    gain_cal_load_a: assert property (
        prim_cal_done && prim_mode == MODE_GAIN_CAL
        |=> prim_gain_coef == $past(prim_cal_value))
        else $error("primary gain calibration result not taken");

    idle_time_a: assert property (
        wr_stb && sel_gain && idle_cnt[0] < IDLE_MIN && !prim_gain_load && !load_factory
        |=> $stable(prim_gain_coef))
        else $error("gain written before idle time elapsed");

    idle_count_a: assert property (
        wr_ok[0] |-> prim_enable && prim_mode == MODE_IDLE
        && $past(prim_enable, 8) && $past(prim_mode, 8) == MODE_IDLE)
        else $error("write window open without idle history");

    refused_write_a: assert property (
        wr_stb && sel_aux_off && !(aux_enable && aux_mode == MODE_IDLE)
        && !aux_offs_load && !load_factory |=> $stable(aux_offset_coef))
        else $error("refused aux write changed coefficient");

    cal_start_a: assert property (
        wr_mode && wdata[MODE_EN_PRIM_BIT] && wdata[MODE_PRIM_LSB+1]
        |=> prim_cal_start ##1 (!prim_cal_start || $past(wr_mode)))
        else $error("calibration start not a single pulse");

endmodule
`default_nettype wire

// [rtl/cal_coeff_pkg.sv]
`default_nettype none
package cal_coeff_pkg;

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [31:0] ADDR_PRIM_OFFSET = 32'hFFFF0524;
    localparam logic [31:0] ADDR_AUX_OFFSET = 32'hFFFF0528;
    localparam logic [31:0] ADDR_PRIM_GAIN = 32'hFFFF052C;
    localparam logic [31:0] ADDR_MODE = 32'hFFFF0540;
    localparam logic [31:0] ADDR_STATUS = 32'hFFFF0544;

    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int COEF_W = 16;
    localparam int MODE_PRIM_LSB = 0;
    localparam int MODE_AUX_LSB = 4;
    localparam int MODE_EN_PRIM_BIT = 8;
    localparam int MODE_EN_AUX_BIT = 9;
    localparam int STAT_WROK_LSB = 0;
    localparam int STAT_BUSY_LSB = 2;

    // converter mode codes, two bits per converter
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_CONT = 2'h1;
    localparam logic [1:0] MODE_OFFS_CAL = 2'h2;
    localparam logic [1:0] MODE_GAIN_CAL = 2'h3;

    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic [15:0] COEF_RESET = 16'h0000;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam int GAIN_FRAC = 15;
    localparam int CLK_PERIOD_NS = 40;
    localparam int IDLE_MIN_NS = 23000;
    localparam int IDLE_MIN_CYC = (IDLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_CNT_W = 10;
    localparam logic [IDLE_CNT_W-1:0] IDLE_MIN = IDLE_MIN_CYC[IDLE_CNT_W-1:0];

endpackage
`default_nettype wire
